/* adcsq_pkg.sv */
// Purpose: shared constants and types for the converter sequencing block
// Assumes: 100 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: register offsets are byte addresses of aligned words
// What this block does
// R1: bit 4 picks single or repeated multi-channel
// R2: bit 3 picks 134 or 70 state conversion
// R3: software clears go before changing speed
// R4: channel field picks input or group 0..n
// R5: trigger enable bit 7 gates the pin
// R6: edge polarity bit picks rising or falling
// R7: trigger register bits 6..4 read one
// R8: bits 3,2,0 writable, reset zero, keep zero
// R9: bit 1 resets one, reads one
// R10: ten bit successive approximation result
// R11: software clears go before mode/channel change
// R12: go with new settings in one write
// R13: single mode starts when go becomes one
// R14: single result lands in channel's register
// R15: completion sets done, irq if enabled
// R16: single mode go self-clears, then idle
// R17: multi mode loops group, done after last
// R18: result in bits 15..6, low bits zero
// R19: done clears on zero write after read
// R20: trigger pin synchronised before edge detect
package adcsq_pkg;
   localparam int ADCSQ_DATA_W  = 32;
   localparam int ADCSQ_ADDR_W  = 8;
   localparam int ADCSQ_RES_W   = 10;
   localparam int ADCSQ_NCH     = 4;
   localparam int ADCSQ_CHSEL_W = 3;

   localparam logic [7:0] ADCSQ_OFS_CSR   = 8'h00;
   localparam logic [7:0] ADCSQ_OFS_TRG   = 8'h04;
   localparam logic [7:0] ADCSQ_OFS_EDGE  = 8'h08;
   localparam logic [7:0] ADCSQ_OFS_RES0  = 8'h10;

   localparam int ADCSQ_CSR_DONE  = 7;
   localparam int ADCSQ_CSR_IEN   = 6;
   localparam int ADCSQ_CSR_GO    = 5;
   localparam int ADCSQ_CSR_MULTI = 4;
   localparam int ADCSQ_CSR_SPEED = 3;
   localparam int ADCSQ_TRG_EN    = 7;
   localparam int ADCSQ_EDGE_POL  = 0;
   localparam int ADCSQ_RES_LSB   = 6;

   localparam logic [7:0] ADCSQ_TRG_FIXED1 = 8'h72;
   localparam logic [7:0] ADCSQ_TRG_WMASK  = 8'h8D;
   localparam logic [7:0] ADCSQ_TRG_RST    = 8'h72;

   localparam int ADCSQ_SLOW_STATES = 134;
   localparam int ADCSQ_FAST_STATES = 70;
   localparam int ADCSQ_CLK_MHZ     = 100;
   localparam int ADCSQ_STATE_NS    = 10;
   localparam int ADCSQ_SLOW_CYC    = (ADCSQ_SLOW_STATES * ADCSQ_STATE_NS * ADCSQ_CLK_MHZ + 999) / 1000;
   localparam int ADCSQ_FAST_CYC    = (ADCSQ_FAST_STATES * ADCSQ_STATE_NS * ADCSQ_CLK_MHZ + 999) / 1000;
   localparam int ADCSQ_CNT_W       = 8;

   localparam logic [1:0] ADCSQ_RESP_OKAY   = 2'b00;
   localparam logic [1:0] ADCSQ_RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ADCSQ_IDLE = 2'b00,
      ADCSQ_CONV = 2'b01,
      ADCSQ_DONE = 2'b10
   } adcsq_state_t;
endpackage

/* adcsq_sar_if.sv */
`timescale 1ns/1ps
// Purpose: handshake between sequencer and the successive approximation engine
// Assumes: one conversion in flight at a time
// Notes: start is a one-cycle pulse, done a one-cycle pulse
interface adcsq_sar_if #(parameter int RES_W = 10);
   logic             start;
   logic [RES_W-1:0] sample;
   logic             compDone;
   logic [RES_W-1:0] result;
   logic             busy;
   modport seq (output start, output sample, input compDone, input result, input busy);
   modport sar (input start, input sample, output compDone, output result, output busy);
endinterface

/* adcsq_sar.sv */
`timescale 1ns/1ps
// Purpose: ten-bit successive approximation engine, one bit decided per step
// Assumes: comparator modelled digitally against the sampled input word
// Notes: takes RES_W steps after start, then pulses compDone
module adcsq_sar #(
   parameter int RES_W = 10
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   adcsq_sar_if.sar  sar
);
   logic [RES_W-1:0] trial_r;
   logic [RES_W-1:0] held_r;
   logic [RES_W-1:0] bitPos_r;
   logic             busy_r;
   logic             done_r;
   logic [RES_W-1:0] guess;
   logic             keep;

   assign guess = trial_r | bitPos_r;
   // comparator: keep the trial bit while the guess does not exceed the input
   assign keep  = (guess <= held_r);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trial_r  <= '0;
         held_r   <= '0;
         bitPos_r <= '0;
         busy_r   <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (sar.start) begin
            held_r   <= sar.sample;
            trial_r  <= '0;
            bitPos_r <= {1'b1, {(RES_W-1){1'b0}}};
            busy_r   <= 1'b1;
         end else if (busy_r) begin
            if (keep) trial_r <= guess; // R10
            bitPos_r <= bitPos_r >> 1;
            if (bitPos_r[0]) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign sar.result   = trial_r;
   assign sar.compDone = done_r;
   assign sar.busy     = busy_r;
endmodule

/* adcsq_top.sv */
`timescale 1ns/1ps
// Purpose: register file and sequencing for a four-input ten-bit converter
// Assumes: AXI4-Lite master keeps one read and one write in flight at most
// Notes: analog inputs arrive as digitised words; the timer sets conversion length
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int SLOW_CYC = ADCSQ_SLOW_CYC,
   parameter int FAST_CYC = ADCSQ_FAST_CYC
) (
   input  wire logic                              clk_sys,
   input  wire logic                              nrst,
   input  wire logic [adcsq_pkg::ADCSQ_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [adcsq_pkg::ADCSQ_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic [1:0]                             s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [adcsq_pkg::ADCSQ_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic [adcsq_pkg::ADCSQ_DATA_W-1:0]     s_axi_rdata,
   output logic [1:0]                             s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   input  wire logic [adcsq_pkg::ADCSQ_RES_W-1:0] analog_in_0,
   input  wire logic [adcsq_pkg::ADCSQ_RES_W-1:0] analog_in_1,
   input  wire logic [adcsq_pkg::ADCSQ_RES_W-1:0] analog_in_2,
   input  wire logic [adcsq_pkg::ADCSQ_RES_W-1:0] analog_in_3,
   input  wire logic                              ext_start_pin,
   output logic                                   conv_done_irq
);
   import adcsq_pkg::*;

   adcsq_sar_if #(.RES_W(ADCSQ_RES_W)) sarBus ();

   adcsq_sar #(.RES_W(ADCSQ_RES_W)) uSar (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sar     (sarBus)
   );

   // register state
   logic                   doneFlag_r;
   logic                   doneSeen_r;
   logic                   irqEn_r;
   logic                   go_r;
   logic                   multi_r;
   logic                   speed_r;
   logic [2:0]             chSel_r;
   logic [7:0]             trgCtl_r;
   logic                   edgePol_r;
   logic [ADCSQ_RES_W-1:0] result_r [ADCSQ_NCH];

   // sequencer state
   adcsq_state_t           state_r;
   adcsq_state_t           state_nxt;
   logic [1:0]             curCh_r;
   logic [ADCSQ_CNT_W-1:0] timer_r;
   logic                   trgMeta_r;
   logic                   trgSync_r;
   logic                   trgPrev_r;

   // bus state
   logic                   awHeld_r;
   logic                   wHeld_r;
   logic [7:0]             awAddr_r;
   logic [31:0]            wData_r;
   logic [3:0]             wStrb_r;
   logic                   bValid_r;
   logic [1:0]             bResp_r;
   logic                   rValid_r;
   logic [31:0]            rData_r;
   logic [1:0]             rResp_r;

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == ADCSQ_OFS_CSR) || (a == ADCSQ_OFS_TRG) || (a == ADCSQ_OFS_EDGE)
                 || ((a >= ADCSQ_OFS_RES0) && (a < ADCSQ_OFS_RES0 + 8'(4 * ADCSQ_NCH))
                     && (a[1:0] == 2'b00));
   endfunction

   // write channel
   wire        wrFire     = awHeld_r && wHeld_r && !bValid_r;
   wire        wrCsr      = wrFire && (awAddr_r == ADCSQ_OFS_CSR) && wStrb_r[0];
   wire        wrTrg      = wrFire && (awAddr_r == ADCSQ_OFS_TRG) && wStrb_r[0];
   wire        wrEdge     = wrFire && (awAddr_r == ADCSQ_OFS_EDGE) && wStrb_r[0];
   wire [7:0]  wByte      = wData_r[7:0];
   wire        swGoSet    = wrCsr && wByte[ADCSQ_CSR_GO] && !go_r;
   wire        swGoClr    = wrCsr && !wByte[ADCSQ_CSR_GO];

   // read channel
   wire        rdFire     = s_axi_arvalid && s_axi_arready;
   wire [7:0]  csrView    = {doneFlag_r, irqEn_r, go_r, multi_r, speed_r, chSel_r};
   wire [7:0]  trgView    = (trgCtl_r & ADCSQ_TRG_WMASK) | ADCSQ_TRG_FIXED1; // R7 R9
   wire [1:0]  rdIdx      = 2'(s_axi_araddr[3:2]);
   wire [15:0] resView    = {result_r[rdIdx], {ADCSQ_RES_LSB{1'b0}}}; // R18
   wire        rdCsr      = rdFire && (s_axi_araddr == ADCSQ_OFS_CSR);

   // trigger edge, taken from the second synchroniser stage only
   wire        trgRise    = trgSync_r && !trgPrev_r;
   wire        trgFall    = !trgSync_r && trgPrev_r;
   wire        trgEdge    = edgePol_r ? trgRise : trgFall; // R6
   wire        hwGoSet    = trgCtl_r[ADCSQ_TRG_EN] && trgEdge && !go_r; // R5

   // sequencing
   wire        startReq   = swGoSet || hwGoSet; // R12 R13
   wire [1:0]  lastCh     = 2'(chSel_r[1:0]);
   wire        convEnd    = (state_r == ADCSQ_CONV) && (timer_r == '0) && !sarBus.busy;
   wire        groupEnd   = !multi_r || (curCh_r == lastCh);
   wire [1:0]  startCh    = multi_r ? 2'b00 : lastCh; // R4
   wire [1:0]  sampleCh   = (state_r == ADCSQ_IDLE) ? startCh : curCh_r;
   wire [ADCSQ_CNT_W-1:0] convLen = speed_r ? ADCSQ_CNT_W'(FAST_CYC - 1)
                                            : ADCSQ_CNT_W'(SLOW_CYC - 1); // R2
   // in idle the channel comes straight from the settings, so a write that sets
   // go together with a new channel samples that channel, not the old one
   wire        goSetEvt   = convEnd && groupEnd; // R15 R17

   logic [ADCSQ_RES_W-1:0] chInput;
   always_comb begin
      unique case (sampleCh)
         2'd0: chInput = analog_in_0;
         2'd1: chInput = analog_in_1;
         2'd2: chInput = analog_in_2;
         2'd3: chInput = analog_in_3;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ADCSQ_IDLE: if (go_r) state_nxt = ADCSQ_CONV;
         ADCSQ_CONV: begin
            if (!go_r) state_nxt = ADCSQ_IDLE;
            else if (convEnd) state_nxt = ADCSQ_DONE;
         end
         ADCSQ_DONE: state_nxt = (multi_r && go_r) ? ADCSQ_CONV : ADCSQ_IDLE; // R1 R17
         default: state_nxt = ADCSQ_IDLE;
      endcase
   end

   assign sarBus.start  = (state_nxt == ADCSQ_CONV) && (state_r != ADCSQ_CONV);
   assign sarBus.sample = chInput;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trgMeta_r <= 1'b1;
         trgSync_r <= 1'b1;
         trgPrev_r <= 1'b1;
      end else begin
         trgMeta_r <= ext_start_pin; // R20
         trgSync_r <= trgMeta_r;
         trgPrev_r <= trgSync_r;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r <= ADCSQ_IDLE;
         timer_r <= '0;
         curCh_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (sarBus.start) timer_r <= convLen;
         else if (timer_r != '0) timer_r <= timer_r - 1'b1;
         // next channel is fixed when a conversion ends, so the DONE hop starts the right one
         if (state_r == ADCSQ_IDLE) curCh_r <= startCh;
         else if (convEnd) curCh_r <= groupEnd ? startCh : curCh_r + 1'b1; // R17
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < ADCSQ_NCH; i++) result_r[i] <= '0;
      end else if (convEnd) begin
         result_r[curCh_r] <= sarBus.result; // R14
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irqEn_r   <= 1'b0;
         multi_r   <= 1'b0;
         speed_r   <= 1'b0;
         chSel_r   <= '0;
         trgCtl_r  <= ADCSQ_TRG_RST; // R8
         edgePol_r <= 1'b0;
      end else begin
         if (wrCsr) begin
            irqEn_r <= wByte[ADCSQ_CSR_IEN];
            // R3 R11: changes while go is set are taken as written; software keeps go clear
            multi_r <= wByte[ADCSQ_CSR_MULTI];
            speed_r <= wByte[ADCSQ_CSR_SPEED];
            chSel_r <= wByte[ADCSQ_CHSEL_W-1:0];
         end
         if (wrTrg) trgCtl_r <= wByte & ADCSQ_TRG_WMASK; // R8
         if (wrEdge) edgePol_r <= wByte[ADCSQ_EDGE_POL];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         go_r <= 1'b0;
      end else if (startReq) begin
         go_r <= 1'b1;
      end else if (swGoClr || (goSetEvt && !multi_r)) begin
         go_r <= 1'b0; // R16
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         doneFlag_r <= 1'b0;
         doneSeen_r <= 1'b0;
      end else begin
         if (goSetEvt) doneFlag_r <= 1'b1; // set beats a same-cycle clear
         else if (wrCsr && !wByte[ADCSQ_CSR_DONE] && doneSeen_r) doneFlag_r <= 1'b0; // R19
         if (rdCsr && doneFlag_r) doneSeen_r <= 1'b1;
         else if (wrCsr || !doneFlag_r) doneSeen_r <= 1'b0;
      end
   end

   assign conv_done_irq = doneFlag_r && irqEn_r; // R15

   // AXI4-Lite slave
   assign s_axi_awready = !awHeld_r;
   assign s_axi_wready  = !wHeld_r;
   assign s_axi_arready = !rValid_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rdata   = rData_r;
   assign s_axi_rresp   = rResp_r;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= '0;
         wData_r  <= '0;
         wStrb_r  <= '0;
         bValid_r <= 1'b0;
         bResp_r  <= ADCSQ_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            bValid_r <= 1'b1;
            // result words are read-only; writes to them answer with an error
            bResp_r  <= (isMapped(awAddr_r) && awAddr_r < ADCSQ_OFS_RES0) ? ADCSQ_RESP_OKAY
                                                                          : ADCSQ_RESP_SLVERR;
         end else if (bValid_r && s_axi_bready) begin
            bValid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rValid_r <= 1'b0;
         rData_r  <= '0;
         rResp_r  <= ADCSQ_RESP_OKAY;
      end else if (rdFire) begin
         rValid_r <= 1'b1;
         rResp_r  <= isMapped(s_axi_araddr) ? ADCSQ_RESP_OKAY : ADCSQ_RESP_SLVERR;
         if (s_axi_araddr == ADCSQ_OFS_CSR) rData_r <= {24'h000000, csrView};
         else if (s_axi_araddr == ADCSQ_OFS_TRG) rData_r <= {24'h000000, trgView};
         else if (s_axi_araddr == ADCSQ_OFS_EDGE) rData_r <= {31'h00000000, edgePol_r};
         else if (isMapped(s_axi_araddr)) rData_r <= {16'h0000, resView};
         else rData_r <= '0;
      end else if (rValid_r && s_axi_rready) begin
         rValid_r <= 1'b0;
      end
   end
endmodule

/* adcsq_chk.sv */
// Purpose: port-level assertions for the converter sequencing block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: the last read address is kept so the answer can be judged by target
`timescale 1ns/1ps
module adcsq_chk
   import adcsq_pkg::*;
(
   input wire logic                                clk_sys,
   input wire logic                                nrst,
   input wire logic                                s_axi_awvalid,
   input wire logic                                s_axi_awready,
   input wire logic                                s_axi_wvalid,
   input wire logic                                s_axi_wready,
   input wire logic [1:0]                          s_axi_bresp,
   input wire logic                                s_axi_bvalid,
   input wire logic                                s_axi_bready,
   input wire logic [adcsq_pkg::ADCSQ_ADDR_W-1:0]  s_axi_araddr,
   input wire logic                                s_axi_arvalid,
   input wire logic                                s_axi_arready,
   input wire logic [adcsq_pkg::ADCSQ_DATA_W-1:0]  s_axi_rdata,
   input wire logic [1:0]                          s_axi_rresp,
   input wire logic                                s_axi_rvalid,
   input wire logic                                s_axi_rready,
   input wire logic                                conv_done_irq
);
   logic [7:0] lastAr_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) lastAr_r <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) lastAr_r <= s_axi_araddr;
   end
   wire resArea = (lastAr_r[7:4] == 4'h1) && (lastAr_r[1:0] == 2'b00);
   wire mapped  = resArea || lastAr_r == ADCSQ_OFS_CSR || lastAr_r == ADCSQ_OFS_TRG || lastAr_r == ADCSQ_OFS_EDGE;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   a_b_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_b_holds: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_trg_fixed: assert property (
      s_axi_rvalid && lastAr_r == ADCSQ_OFS_TRG |-> s_axi_rdata[6:4] == 3'h7 && s_axi_rdata[1])
      else $error("trigger fixed bits wrong");
   a_res_format: assert property (
      s_axi_rvalid && resArea |-> s_axi_rdata[5:0] == 6'h00 && s_axi_rdata[31:16] == 16'h0000)
      else $error("result padding not zero");
   a_unmapped_err: assert property (
      s_axi_rvalid && !mapped |-> s_axi_rresp == ADCSQ_RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
   a_irq_clear: assert property ($fell(conv_done_irq) |-> s_axi_bvalid) else $error("irq fell without write");
   a_reset_quiet: assert property ($rose(nrst) |-> !s_axi_bvalid && !s_axi_rvalid && !conv_done_irq)
      else $error("outputs busy after reset");
endmodule

/* adcsq_far.sv */
// Purpose: model of the far side: digitised analog sources and trigger source
// Assumes: trigger pin idles high
// Notes: a pulse offers both a falling and a rising edge
`timescale 1ns/1ps
module adcsq_far
   import adcsq_pkg::*;
(
   input  wire logic                              clk_sys,
   output logic [adcsq_pkg::ADCSQ_RES_W-1:0]      analog_in_0,
   output logic [adcsq_pkg::ADCSQ_RES_W-1:0]      analog_in_1,
   output logic [adcsq_pkg::ADCSQ_RES_W-1:0]      analog_in_2,
   output logic [adcsq_pkg::ADCSQ_RES_W-1:0]      analog_in_3,
   output logic                                   ext_start_pin
);
   logic [ADCSQ_RES_W-1:0] lvl[4] = '{10'h000, 10'h000, 10'h000, 10'h000};
   assign analog_in_0 = lvl[0];
   assign analog_in_1 = lvl[1];
   assign analog_in_2 = lvl[2];
   assign analog_in_3 = lvl[3];
   initial ext_start_pin = 1'b1;
   task automatic setIn(input int ch, input logic [ADCSQ_RES_W-1:0] v);
      @(posedge clk_sys);
      lvl[ch] <= v;
   endtask
   // low long enough to pass the two-flop synchroniser
   task automatic pulse();
      @(posedge clk_sys);
      ext_start_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      ext_start_pin <= 1'b1;
   endtask
endmodule

/* test_adc_sequence_control.sv */
// Purpose: self-checking bench for the converter sequencing block
// Assumes: short conversion counts so the run stays brief
// Notes: read and write answers are compared against queued notes
`timescale 1ns/1ps
module test_adc_sequence_control;
   import adcsq_pkg::*;
   localparam logic [1:0] OK = ADCSQ_RESP_OKAY;
   localparam logic [1:0] SE = ADCSQ_RESP_SLVERR;
   localparam logic [33:0] RSTV[8] = '{34'h0, 34'h72, 34'h0, {SE, 32'h0}, 34'h0, 34'h0, 34'h0, 34'h0};
   logic        clk_sys = 1'b0, nrst = 1'b0, ext_start_pin, conv_done_irq;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, wrQ[$];
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [9:0]  analog_in_0, analog_in_1, analog_in_2, analog_in_3, v;
   logic [34:0] rdQ[$], rn;
   logic [7:0]  csr;
   int          badCount = 0, numChecks = 0;
   always #5 clk_sys = ~clk_sys;
   adcsq_top #(.SLOW_CYC(12), .FAST_CYC(11)) DUT (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .analog_in_0, .analog_in_1, .analog_in_2, .analog_in_3, .ext_start_pin, .conv_done_irq);
   adcsq_far far (.clk_sys, .analog_in_0, .analog_in_1, .analog_in_2, .analog_in_3, .ext_start_pin);
   task automatic final_report();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      numChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bound(input int n);
      if (n >= 400) begin
         check(34'h0, 34'h1);
         final_report();
      end
   endtask
   always @(posedge clk_sys) begin
      if (s_axi_rvalid && s_axi_rready) begin
         rn = rdQ.pop_front();
         if (rn[34]) check({s_axi_rresp, s_axi_rdata}, rn[33:0]);
      end
      if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, wrQ.pop_front()});
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [1:0] er);
      int n = 0;
      wrQ.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, dat};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 400);
      bound(n);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic chk, input logic [33:0] exp, output logic [31:0] q);
      int n = 0;
      rdQ.push_back({chk, exp});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 400);
      bound(n);
      q = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic pollv(input logic [7:0] a, input logic [31:0] m, input logic [31:0] val);
      int n = 0;
      logic [31:0] q;
      do begin
         rd(a, 1'b0, 34'h0, q);
         n++;
      end while ((q & m) != val && n < 400);
      bound(n);
   endtask
   task automatic waitIrq();
      int n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (conv_done_irq !== 1'b1 && n < 400);
      bound(n);
   endtask
   initial begin
      void'($urandom(86));
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 1'b1, RSTV[i], d);
      $display("test reset values done");
      repeat (4) begin
         csr = 8'($urandom) & 8'hF2;
         wr(ADCSQ_OFS_TRG, csr, OK);
         rd(ADCSQ_OFS_TRG, 1'b1, {OK, 24'h0, 8'h72 | (csr & 8'h8D)}, d);
      end
      wr(ADCSQ_OFS_TRG, 8'h00, OK);
      wr(ADCSQ_OFS_RES0, 8'hFF, SE);
      rd(ADCSQ_OFS_RES0, 1'b1, 34'h0, d);
      $display("test register access done");
      for (int c = 0; c < 4; c++) begin
         v = 10'($urandom);
         far.setIn(c, v);
         csr = 8'h20 | (c[0] ? 8'h08 : 8'h00) | 8'(c);
         wr(ADCSQ_OFS_CSR, csr, OK);
         pollv(ADCSQ_OFS_CSR, 32'h20, 32'h0);
         rd(ADCSQ_OFS_CSR, 1'b1, {OK, 24'h0, 8'h80 | (csr & 8'h1F)}, d);
         rd(ADCSQ_OFS_RES0 + 8'(4 * c), 1'b1, {OK, 16'h0, v, 6'h00}, d);
         wr(ADCSQ_OFS_CSR, csr & 8'h1F, OK);
      end
      rd(ADCSQ_OFS_CSR, 1'b1, {OK, 32'h0B}, d);
      $display("test single conversions done");
      wr(ADCSQ_OFS_CSR, 8'h61, OK);
      waitIrq();
      wr(ADCSQ_OFS_CSR, 8'h41, OK);
      check({33'h0, conv_done_irq}, 34'h1);
      rd(ADCSQ_OFS_CSR, 1'b1, {OK, 32'hC1}, d);
      wr(ADCSQ_OFS_CSR, 8'h01, OK);
      check({33'h0, conv_done_irq}, 34'h0);
      $display("test done flag done");
      wr(ADCSQ_OFS_CSR, 8'h7B, OK);
      waitIrq();
      for (int c = 0; c < 4; c++) begin
         v = 10'($urandom);
         far.setIn(c, v);
         pollv(ADCSQ_OFS_RES0 + 8'(4 * c), 32'hFFC0, {16'h0, v, 6'h00});
      end
      wr(ADCSQ_OFS_CSR, 8'h5B, OK);
      wr(ADCSQ_OFS_CSR, 8'h0B, OK);
      rd(ADCSQ_OFS_CSR, 1'b1, {OK, 32'h8B}, d);
      wr(ADCSQ_OFS_CSR, 8'h02, OK);
      $display("test group conversion done");
      far.pulse();
      repeat (60) @(posedge clk_sys);
      rd(ADCSQ_OFS_CSR, 1'b1, {OK, 32'h02}, d);
      wr(ADCSQ_OFS_TRG, 8'h80, OK);
      for (int p = 0; p < 2; p++) begin
         wr(ADCSQ_OFS_EDGE, 8'(p), OK);
         v = 10'($urandom);
         far.setIn(2, v);
         far.pulse();
         pollv(ADCSQ_OFS_CSR, 32'hA0, 32'h80);
         rd(ADCSQ_OFS_RES2_OFS(), 1'b1, {OK, 16'h0, v, 6'h00}, d);
         wr(ADCSQ_OFS_CSR, 8'h02, OK);
      end
      repeat (60) @(posedge clk_sys);
      rd(ADCSQ_OFS_CSR, 1'b1, {OK, 32'h02}, d);
      $display("test external trigger done");
      final_report();
   end
   function automatic logic [7:0] ADCSQ_OFS_RES2_OFS();
      return ADCSQ_OFS_RES0 + 8'h08;
   endfunction
endmodule

bind adcsq_top adcsq_chk chk (.clk_sys, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_done_irq);
